// ===== include/ddrb_defs.svh
`ifndef DDRB_DEFS_SVH
`define DDRB_DEFS_SVH
// data word and byte lane geometry of the wide organisation
`define DDRB_WORD_W 36
`define DDRB_LANE_W 9
`define DDRB_LANES 4
// bits kept in the narrow organisation
`define DDRB_X18_MASK 36'h0_0003_ffff
// burst address width and array depth, one entry per two-word burst
`define DDRB_ADDR_W 6
`define DDRB_DEPTH 64
// state reset value
`define DDRB_RST_ZERO 1'b0
`endif

// ===== include/ddrb_pkg.sv
`include "ddrb_defs.svh"
package ddrb_pkg;
  typedef logic [`DDRB_WORD_W-1:0] ddrb_word_t;
  typedef logic [`DDRB_ADDR_W-1:0] ddrb_addr_t;
  typedef logic [`DDRB_LANES-1:0] ddrb_lane_t;

  // control pins sampled at the positive clock rise
  typedef struct packed {
    logic load_strobe_n;
    logic rw;
    ddrb_addr_t addr;
  } ddrb_cmd_s;

  // one data half of a write: word plus its active-low byte selects
  typedef struct packed {
    ddrb_word_t data;
    ddrb_lane_t byte_write_select_n;
  } ddrb_half_s;

  // one burst: w0 at address A, w1 at A+1
  typedef struct packed {
    ddrb_word_t w1;
    ddrb_word_t w0;
  } ddrb_burst_s;

  typedef enum logic [1:0] {
    DDRB_IDLE  = 2'b00,
    DDRB_WRITE = 2'b01,
    DDRB_READ  = 2'b10
  } ddrb_op_e;

  typedef struct packed {
    ddrb_op_e op;
    ddrb_addr_t addr;
    logic x36;
    logic fwd_v;
    ddrb_burst_s fwd;
    ddrb_lane_t fwd_l0;
    ddrb_lane_t fwd_l1;
    ddrb_word_t q_fall;
    logic q_fall_oe;
    ddrb_word_t q_rise;
    logic q_rise_oe;
    ddrb_word_t pend;
    logic pend_v;
  } ddrb_port_st_s;
endpackage : ddrb_pkg

// ===== hdl/ddrb_mem.sv
`timescale 1ns/10ps
`default_nettype none
`include "ddrb_defs.svh"
module ddrb_mem (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic rd_en_i,
  input wire ddrb_pkg::ddrb_addr_t rd_addr_i,
  output ddrb_pkg::ddrb_burst_s rd_data_o,
  input wire logic we_i,
  input wire ddrb_pkg::ddrb_addr_t wr_addr_i,
  input wire ddrb_pkg::ddrb_burst_s wr_data_i,
  input wire ddrb_pkg::ddrb_lane_t lane0_i,
  input wire ddrb_pkg::ddrb_lane_t lane1_i
);
  import ddrb_pkg::*;

  typedef struct packed {
    ddrb_burst_s [`DDRB_DEPTH-1:0] arr;
    ddrb_burst_s rdata;
  } ddrb_mem_st_s;

  ddrb_mem_st_s s_q;
  ddrb_mem_st_s s_d;

  // lanes of each word are enabled separately; a word with no lane is left alone
  always_comb begin
    s_d = s_q;
    if (rd_en_i) begin
      s_d.rdata = s_q.arr[rd_addr_i];
    end
    for (int i = 0; i < `DDRB_LANES; i++) begin
      if (we_i && lane0_i[i]) begin
        s_d.arr[wr_addr_i].w0[i*`DDRB_LANE_W +: `DDRB_LANE_W] =
          wr_data_i.w0[i*`DDRB_LANE_W +: `DDRB_LANE_W];
      end
      if (we_i && lane1_i[i]) begin
        s_d.arr[wr_addr_i].w1[i*`DDRB_LANE_W +: `DDRB_LANE_W] =
          wr_data_i.w1[i*`DDRB_LANE_W +: `DDRB_LANE_W];
      end
    end
    if (!resetn_i) begin
      s_d = '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    s_q <= s_d;
  end

  assign rd_data_o = s_q.rdata;
endmodule : ddrb_mem
`default_nettype wire

// ===== hdl/ddrb_buf.sv
`timescale 1ns/10ps
`default_nettype none
module ddrb_buf (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire ddrb_pkg::ddrb_burst_s in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output ddrb_pkg::ddrb_burst_s out_data_o
);
  import ddrb_pkg::*;

  typedef struct packed {
    ddrb_burst_s [1:0] ent;
    logic wr;
    logic rd;
    logic [1:0] cnt;
  } ddrb_buf_st_s;

  ddrb_buf_st_s s_q;
  ddrb_buf_st_s s_d;
  logic push;
  logic pop;

  // handshakes straight from the count, so full and empty are exact
  assign in_ready_o = (s_q.cnt != 2'h2);
  assign out_valid_o = (s_q.cnt != 2'h0);
  assign out_data_o = s_q.ent[s_q.rd];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // two-entry ring; push and pop in one cycle leave the count alone
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.ent[s_q.wr] = in_data_i;
      s_d.wr = ~s_q.wr;
    end
    if (pop) begin
      s_d.rd = ~s_q.rd;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 2'h1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 2'h1;
    end
    if (!resetn_i) begin
      s_d = '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    s_q <= s_d;
  end
endmodule : ddrb_buf
`default_nettype wire

// ===== hdl/ddrb_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "ddrb_defs.svh"
module ddrb_port (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic k_running_i,
  input wire logic org_x36_i,
  input wire ddrb_pkg::ddrb_cmd_s cmd_i,
  input wire ddrb_pkg::ddrb_half_s d_rise_i,
  input wire ddrb_pkg::ddrb_half_s d_fall_i,
  output logic cmd_ready_o,
  output ddrb_pkg::ddrb_word_t q_fall_o,
  output logic q_fall_oe_o,
  output ddrb_pkg::ddrb_word_t q_rise_o,
  output logic q_rise_oe_o
);
  import ddrb_pkg::*;

  ddrb_port_st_s s_q;
  ddrb_port_st_s s_d;
  logic rd_acc;
  logic wr_acc;
  logic mem_we;
  logic push_v;
  logic push_rdy;
  logic pop_v;
  logic pop_rdy;
  ddrb_burst_s rd_burst;
  ddrb_burst_s push_data;
  ddrb_burst_s head;
  ddrb_burst_s wr_burst;
  ddrb_lane_t lane0;
  ddrb_lane_t lane1;
  ddrb_word_t word_mask;

  // narrow mode keeps only the low 18 bits on both paths
  assign word_mask = s_q.x36 ? '1 : `DDRB_X18_MASK;

  // the write data half pair is taken in the cycle after the command
  assign wr_burst.w0 = d_rise_i.data & word_mask;
  assign wr_burst.w1 = d_fall_i.data & word_mask;

  // per-word lane enables; each half uses only its own select pattern
  always_comb begin
    lane0 = ~d_rise_i.byte_write_select_n;
    lane1 = ~d_fall_i.byte_write_select_n;
    if (!s_q.x36) begin
      lane0[3:2] = 2'b00;
      lane1[3:2] = 2'b00;
    end
  end

  // the array is written one edge after a write command, at the latched address
  assign mem_we = (s_q.op == DDRB_WRITE) && k_running_i;

  // a read command is refused while the output buffer has no room
  assign cmd_ready_o = push_rdy;
  assign push_v = (s_q.op == DDRB_READ) && k_running_i;
  // a stopped clock freezes the drain, so a held word is never lost
  assign pop_rdy = k_running_i;

  ddrb_mem u_mem (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .rd_en_i(rd_acc),
    .rd_addr_i(cmd_i.addr),
    .rd_data_o(rd_burst),
    .we_i(mem_we),
    .wr_addr_i(s_q.addr),
    .wr_data_i(wr_burst),
    .lane0_i(lane0),
    .lane1_i(lane1)
  );

  // a read issued while the same burst is being written sees the new lanes
  always_comb begin
    push_data = rd_burst;
    if (s_q.fwd_v) begin
      for (int i = 0; i < `DDRB_LANES; i++) begin
        if (s_q.fwd_l0[i]) begin
          push_data.w0[i*`DDRB_LANE_W +: `DDRB_LANE_W] =
            s_q.fwd.w0[i*`DDRB_LANE_W +: `DDRB_LANE_W];
        end
        if (s_q.fwd_l1[i]) begin
          push_data.w1[i*`DDRB_LANE_W +: `DDRB_LANE_W] =
            s_q.fwd.w1[i*`DDRB_LANE_W +: `DDRB_LANE_W];
        end
      end
    end
  end

  ddrb_buf u_buf (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .in_valid_i(push_v),
    .in_ready_o(push_rdy),
    .in_data_i(push_data),
    .out_valid_o(pop_v),
    .out_ready_i(pop_rdy),
    .out_data_o(head)
  );

  // command decode, output pipeline and reset, all in one next-state process
  always_comb begin
    s_d = s_q;
    rd_acc = 1'b0;
    wr_acc = 1'b0;
    if (k_running_i) begin
      // a read that could not be buffered holds the command stage
      if (!(push_v && !push_rdy)) begin
        s_d.op = DDRB_IDLE;
        s_d.addr = cmd_i.addr;
        if (!cmd_i.load_strobe_n) begin
          unique case (cmd_i.rw)
            1'b1: begin
              if (push_rdy) begin
                s_d.op = DDRB_READ;
                rd_acc = 1'b1;
              end
            end
            1'b0: begin
              s_d.op = DDRB_WRITE;
              wr_acc = 1'b1;
            end
          endcase
        end
        if (rd_acc) begin
          s_d.fwd_v = mem_we && (cmd_i.addr == s_q.addr);
          s_d.fwd = wr_burst;
          s_d.fwd_l0 = lane0;
          s_d.fwd_l1 = lane1;
        end
      end
      // word A on the fall, A+1 on the next rise; pins float when nothing pends
      s_d.q_fall_oe = pop_v;
      s_d.pend_v = pop_v;
      s_d.q_rise = s_q.pend;
      s_d.q_rise_oe = s_q.pend_v;
      if (pop_v) begin
        s_d.q_fall = head.w0 & word_mask;
        s_d.pend = head.w1 & word_mask;
      end
    end
    // the organisation strap is caught while reset is held
    if (!resetn_i) begin
      s_d = '0;
      s_d.x36 = org_x36_i;
    end
  end

  // synchronous reset is folded into the next-state process
  always_ff @(posedge mclk_i) begin
    s_q <= s_d;
  end

  assign q_fall_o = s_q.q_fall;
  assign q_fall_oe_o = s_q.q_fall_oe;
  assign q_rise_o = s_q.q_rise;
  assign q_rise_oe_o = s_q.q_rise_oe;

  // first word drives two edges after the command edge when the clock runs
  rd_first_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    rd_acc ##1 k_running_i [*2] |=> q_fall_oe_o)
    else $error("read first word not driven at latency");

  // second word follows the first by exactly one cycle
  rd_pair_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (q_fall_oe_o && k_running_i) |=> q_rise_oe_o && (q_rise_o == $past(s_q.pend)))
    else $error("read second word missing");

  // after the last rise word the rise pins float
  deselect_hiz_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (q_rise_oe_o && !q_fall_oe_o && k_running_i) |=> !q_rise_oe_o)
    else $error("output driven after burst end");

  // four idle running cycles leave both output halves floating
  idle_hiz_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (k_running_i && cmd_i.load_strobe_n) [*4] |=> !q_fall_oe_o && !q_rise_oe_o)
    else $error("pins driven while idle");

  // held reset leaves the port deselected
  reset_hiz_a: assert property (
    @(posedge mclk_i)
    !resetn_i |=> !q_fall_oe_o && !q_rise_oe_o && !mem_we)
    else $error("outputs driven after reset");

  // stopped clock holds every output
  stop_hold_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    !k_running_i |=> $stable(q_fall_o) && $stable(q_rise_o) && $stable(q_fall_oe_o) &&
      $stable(q_rise_oe_o))
    else $error("outputs moved while clock stopped");

  // write command commits one cycle later at the latched address
  wr_commit_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    wr_acc ##1 k_running_i |-> mem_we && (s_q.addr == $past(cmd_i.addr)))
    else $error("write not committed at address");

  // all selects high means that word writes nothing; the array's next state proves it
  mask_none_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (mem_we && (&d_fall_i.byte_write_select_n)) |-> (lane1 == '0) &&
      (u_mem.s_d.arr[s_q.addr].w1 == u_mem.s_q.arr[s_q.addr].w1))
    else $error("masked word written");

  // narrow mode never touches or shows the upper lanes
  narrow_mode_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    !s_q.x36 |-> (lane0[3:2] == 2'b00) && (q_fall_o[35:18] == '0) && (q_rise_o[35:18] == '0))
    else $error("narrow mode upper bits active");

  // wide mode maps each select onto its own lane; all four low store the whole word
  wide_lane_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (mem_we && s_q.x36) |-> (lane0 == ~d_rise_i.byte_write_select_n) &&
      ((d_rise_i.byte_write_select_n != '0) ||
      (u_mem.s_d.arr[s_q.addr].w0 == d_rise_i.data)))
    else $error("wide mode lane mismatch");

  read_seen_c: cover property (@(posedge mclk_i) disable iff (!resetn_i) rd_acc);
  write_seen_c: cover property (@(posedge mclk_i) disable iff (!resetn_i) wr_acc);
  back_reads_c: cover property (@(posedge mclk_i) disable iff (!resetn_i) rd_acc ##1 rd_acc);
  stop_burst_c: cover property (
    @(posedge mclk_i) disable iff (!resetn_i) q_fall_oe_o && !k_running_i);
endmodule : ddrb_port
`default_nettype wire

// ===== verification/ddrb_ctl_model.sv
`timescale 1ns/10ps
`default_nettype none
module ddrb_ctl_model (
  input wire logic mclk_i,
  output ddrb_pkg::ddrb_cmd_s cmd_o,
  output ddrb_pkg::ddrb_half_s d_rise_o,
  output ddrb_pkg::ddrb_half_s d_fall_o
);
  import ddrb_pkg::*;
  ddrb_half_s pend_r_q;
  ddrb_half_s pend_f_q;
  logic pend_v_q;
  // strobe parked high until the first command
  initial begin
    cmd_o = '{load_strobe_n: 1'b1, rw: 1'b0, addr: '0};
    d_rise_o = '0;
    d_fall_o = '0;
    pend_v_q = 1'b0;
  end
  // one command a cycle; write halves follow one cycle later with their own selects
  // idle data lanes toggle so a stale word is never mistaken for fresh data
  task automatic step(input ddrb_cmd_s c, input ddrb_half_s hr, input ddrb_half_s hf);
    @(negedge mclk_i);
    cmd_o <= c;
    d_rise_o <= pend_v_q ? pend_r_q : ~d_rise_o;
    d_fall_o <= pend_v_q ? pend_f_q : ~d_fall_o;
    pend_r_q <= hr;
    pend_f_q <= hf;
    pend_v_q <= !c.load_strobe_n && !c.rw;
  endtask : step
endmodule : ddrb_ctl_model
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ddrb_defs.svh"
`define DDRB_CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_top;
  import ddrb_pkg::*;
  typedef struct {int due; ddrb_word_t w;} ddrb_exp_s;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic k_running_i = 1'b1;
  logic org_x36_i = 1'b1;
  ddrb_cmd_s cmd;
  ddrb_half_s d_rise;
  ddrb_half_s d_fall;
  logic cmd_ready;
  logic q_fall_oe;
  logic q_rise_oe;
  ddrb_word_t q_fall;
  ddrb_word_t q_rise;
  int fail_count = 0;
  int total_checks = 0;
  int rc = 0;
  logic run_e = 1'b0;
  logic rst_e = 1'b1;
  logic [2*`DDRB_WORD_W+1:0] hold = '0;
  ddrb_word_t ref0 [`DDRB_DEPTH];
  ddrb_word_t ref1 [`DDRB_DEPTH];
  ddrb_exp_s fq[$];
  ddrb_exp_s rq[$];
  logic [31:0] seed = 32'h449c_85ee;
  logic [3:0] sel_tbl [10] = '{4'h0, 4'he, 4'hd, 4'hb, 4'h7, 4'hf, 4'hc, 4'h3, 4'ha, 4'h5};

  always #2.5 mclk_i = ~mclk_i;

  ddrb_port dut_u (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .k_running_i(k_running_i),
    .org_x36_i(org_x36_i), .cmd_i(cmd), .d_rise_i(d_rise), .d_fall_i(d_fall),
    .cmd_ready_o(cmd_ready), .q_fall_o(q_fall), .q_fall_oe_o(q_fall_oe),
    .q_rise_o(q_rise), .q_rise_oe_o(q_rise_oe)
  );
  ddrb_ctl_model ctl_u (.mclk_i(mclk_i), .cmd_o(cmd), .d_rise_o(d_rise), .d_fall_o(d_fall));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // reference merge: a lane changes only when its select is low and it exists
  function automatic ddrb_word_t merge(input ddrb_word_t old, input ddrb_half_s h);
    ddrb_word_t m;
    m = old;
    for (int i = 0; i < `DDRB_LANES; i++) begin
      if (!h.byte_write_select_n[i] && (org_x36_i || i < 2)) begin
        m[i*`DDRB_LANE_W +: `DDRB_LANE_W] = h.data[i*`DDRB_LANE_W +: `DDRB_LANE_W];
      end
    end
    return m;
  endfunction : merge

  task automatic close_out;
    $display("checks %0d, errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  // one cycle of traffic; reads note both words with the running edge they are due on
  task automatic do_op(input logic ldn, input logic rw, input ddrb_addr_t a, input logic run);
    ddrb_half_s hr;
    ddrb_half_s hf;
    seed = lfsr(seed);
    hr = '{data: {seed[3:0], seed}, byte_write_select_n: sel_tbl[seed[7:4] % 10]};
    seed = lfsr(seed);
    hf = '{data: {seed, seed[31:28]}, byte_write_select_n: sel_tbl[seed[11:8] % 10]};
    ctl_u.step('{load_strobe_n: ldn, rw: rw, addr: a}, hr, hf);
    k_running_i <= run;
    if (run && !ldn && !rw) begin
      ref0[a] = merge(ref0[a], hr);
      ref1[a] = merge(ref1[a], hf);
    end else if (run && !ldn) begin
      `DDRB_CHK(cmd_ready, 1'b1)
      fq.push_back(ddrb_exp_s'{rc + 3, ref0[a]});
      rq.push_back(ddrb_exp_s'{rc + 4, ref1[a]});
    end
  endtask : do_op

  // random mix of reads, writes and idle cycles on low and high addresses
  task automatic run_mix(input int n);
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      do_op(seed[1:0] == 2'b11, seed[2], {seed[6] ? 3'b111 : 3'b000, seed[5:3]}, 1'b1);
    end
  endtask : run_mix

  // reset stands in for power-up, so the reference array starts cleared too
  task automatic do_reset(input logic x36);
    resetn_i <= 1'b0;
    org_x36_i <= x36;
    repeat (16) do_op(1'b1, 1'b1, '0, 1'b1);
    resetn_i <= 1'b1;
    foreach (ref0[i]) begin
      ref0[i] = '0;
      ref1[i] = '0;
    end
    fq.delete();
    rq.delete();
  endtask : do_reset

  task automatic drain;
    for (int i = 0; i < 12 && fq.size() + rq.size() > 0; i++) do_op(1'b1, 1'b0, '0, 1'b1);
    if (fq.size() + rq.size() > 0) begin
      fail_count++;
      close_out();
    end
    repeat (2) do_op(1'b1, 1'b1, '0, 1'b1);
  endtask : drain

  // counts running edges; expectations are keyed to this count
  always @(posedge mclk_i) begin
    run_e <= resetn_i && k_running_i;
    rst_e <= !resetn_i;
    if (resetn_i && k_running_i) rc <= rc + 1;
  end

  // an output may drive only on the exact edge its word is due
  task automatic chk_out(input logic oe, input ddrb_word_t q, ref ddrb_exp_s eq[$]);
    logic hit;
    hit = eq.size() > 0 && eq[0].due == rc;
    `DDRB_CHK(oe, hit)
    if (hit) begin
      `DDRB_CHK(q, eq[0].w)
      void'(eq.pop_front());
    end
  endtask : chk_out

  // watcher: reset quiet, due words in order, everything frozen while stopped
  always @(negedge mclk_i) begin
    if (rst_e) begin
      `DDRB_CHK({q_fall_oe, q_rise_oe}, 2'b00)
    end else if (run_e) begin
      chk_out(q_fall_oe, q_fall, fq);
      chk_out(q_rise_oe, q_rise, rq);
      hold <= {q_fall_oe, q_fall, q_rise_oe, q_rise};
    end else begin
      `DDRB_CHK({q_fall_oe, q_fall, q_rise_oe, q_rise}, hold)
    end
  end

  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    close_out();
  end

  initial begin
    do_reset(1'b1);
    // read right behind a write to the same top address sees the new words
    do_op(1'b0, 1'b0, 6'h3f, 1'b1);
    do_op(1'b0, 1'b1, 6'h3f, 1'b1);
    run_mix(150);
    // stop the clock behind two reads; reads offered meanwhile are ignored
    do_op(1'b0, 1'b1, 6'h05, 1'b1);
    do_op(1'b0, 1'b1, 6'h3e, 1'b1);
    repeat (4) do_op(1'b0, 1'b1, 6'h07, 1'b0);
    run_mix(50);
    drain();
    do_reset(1'b0);
    run_mix(150);
    drain();
    close_out();
  end
endmodule : tb_top
`default_nettype wire
